// ===== hdl/pd_mac_reset_timing.sv
`timescale 1ns/100ps
// How it works
// RQ1 - Software pulses each soft reset bit: write one, then write zero.
// RQ2 - After full reset software reprograms the whole MAC and timing limits.
// RQ3 - The full MAC reset bit itself is cleared by external reset.
// RQ4 - Codec reset bit 6 restarts encoder and decoder, limits kept; here it restarts only the decoder meter, not the encoder in the tx fsm.
// RQ5 - Software pulses bit 0 after handling hard or cable reset.
// RQ6 - Protocol reset idles receive fsm; reset detection stays enabled.
// RQ7 - Protocol reset idles transmit fsm, serialiser and encoder.
// RQ8 - Protocol reset clears launch, hard, cable and fast transmit bits.
// RQ9 - Protocol reset leaves other registers and packet counters untouched.
// RQ10 - Protocol reset spares receive buffer, clock recovery, decoder, CRC.
// RQ11 - Protocol reset spares self-test and power management.
// RQ12 - A high full bit is accepted only strictly between min and max.
// RQ13 - Software sets max from slowest rate plus tolerance; 202 advised.
// RQ14 - Software sets min from fastest rate minus tolerance; 116 advised.
// RQ15 - Limits should cover bit rate variation and duty distortion.
// RQ16 - Software keeps full-bit min above half-bit max.
// RQ17 - High time is counted in clocks from rising to falling edge.
// RQ18 - Full MAC reset bit 7 returns the whole MAC to power-on state.
module pd_mac_reset_timing
    import pd_mac_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // Line from partner
    input wire logic line_i,
    // Receive hard or cable reset seen
    input wire logic reset_seen_i,
    // Observed state
    output logic full_bit_o,
    output logic reset_evt_o,
    output logic tx_busy_o
);
    soft_reset_if rst_bus();

    logic line_s1_r;
    logic line_s2_r;
    logic [7:0] fb_max_r;
    logic [7:0] fb_min_r;
    logic [7:0] mac_soft_reset_control_r;
    logic [7:0] mac_ctl_r;
    logic [7:0] good_count_r;
    logic [7:0] bad_count_r;
    logic [7:0] packets_sent_counter_r;
    rx_state_t rx_state_r;
    logic sticky_detect_r;
    logic full_bit;
    logic reject;
    logic tx_busy;
    logic tx_done;
    logic req;
    logic wr;
    logic [15:0] idx;
    logic hit;
    logic [31:0] rd_nxt;
    logic mac_clr;
    logic proto_clr;

    assign req = cyc_i & stb_i & ~ack_o & ~err_o;
    assign idx = adr_i[ADDR_W-1:2];
    assign hit = idx == IDX_HIGH_FULL_BIT_MAX || idx == IDX_HIGH_FULL_BIT_MIN
        || idx == IDX_SOFT_MAC_SOFT_RESET_CONTROL || idx == IDX_DECODER_STATUS
        || idx == IDX_MAC_CONTROL;
    assign wr = req & we_i & sel_i[0] & hit;
    assign mac_clr = rst_i | mac_soft_reset_control_r[BIT_MAC_FULL_RESET];
    assign proto_clr = mac_soft_reset_control_r[BIT_PROTOCOL_RESET_DONE];

    assign rst_bus.mac_reset = mac_soft_reset_control_r[BIT_MAC_FULL_RESET];
    assign rst_bus.codec_reset = mac_soft_reset_control_r[BIT_LINE_CODEC_RESET];
    // Protocol reset reaches only the control fsms and transmit bits
    assign rst_bus.protocol_reset = proto_clr; // RQ10 RQ11

    // Line comes from the partner: two flops before any use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_s1_r <= 1'b0;
            line_s2_r <= 1'b0;
        end else begin
            line_s1_r <= line_i;
            line_s2_r <= line_s1_r;
        end
    end

    // Bus answers in the cycle after the request, one cycle wide
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req & hit;
            err_o <= req & ~hit;
            dat_o <= req ? rd_nxt : 32'h0000_0000;
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (idx)
            IDX_HIGH_FULL_BIT_MAX: rd_nxt[7:0] = fb_max_r;
            IDX_HIGH_FULL_BIT_MIN: rd_nxt[7:0] = fb_min_r;
            IDX_SOFT_MAC_SOFT_RESET_CONTROL: rd_nxt[7:0] = mac_soft_reset_control_r;
            IDX_DECODER_STATUS: rd_nxt = {8'h00, packets_sent_counter_r,
                bad_count_r, good_count_r};
            IDX_MAC_CONTROL: rd_nxt[7:0] = {sticky_detect_r, 1'b0,
                mac_ctl_r[5:0]};
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // Control bits stay set until software writes zero; only rst_i clears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin // RQ3
            mac_soft_reset_control_r <= REG8_RESET;
        end else if (wr && idx == IDX_SOFT_MAC_SOFT_RESET_CONTROL) begin
            mac_soft_reset_control_r <= dat_i[7:0] & MAC_SOFT_RESET_CONTROL_MASK;
        end
    end

    // Limits survive codec and protocol resets, not the full reset
    always_ff @(posedge clk_i) begin
        if (mac_clr) begin // RQ18
            fb_max_r <= LIMIT_RESET;
            fb_min_r <= LIMIT_RESET;
        end else if (wr) begin // RQ4
            if (idx == IDX_HIGH_FULL_BIT_MAX) fb_max_r <= dat_i[7:0];
            if (idx == IDX_HIGH_FULL_BIT_MIN) fb_min_r <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (mac_clr) begin
            mac_ctl_r <= REG8_RESET;
        end else if (proto_clr) begin // RQ8
            mac_ctl_r[BIT_TX_LAUNCH] <= 1'b0;
            mac_ctl_r[BIT_TX_HARD_RESET] <= 1'b0;
            mac_ctl_r[BIT_TX_CABLE_RESET] <= 1'b0;
            mac_ctl_r[BIT_FAST_TX_ENABLE] <= 1'b0;
        end else if (wr && idx == IDX_MAC_CONTROL) begin
            mac_ctl_r <= dat_i[7:0] & MAC_CONTROL_MASK;
        end else if (tx_done) begin
            mac_ctl_r[BIT_TX_LAUNCH] <= 1'b0;
        end
    end

    // Counters are spared by the protocol reset
    always_ff @(posedge clk_i) begin
        if (mac_clr) begin // RQ9
            good_count_r <= REG8_RESET;
            bad_count_r <= REG8_RESET;
            packets_sent_counter_r <= REG8_RESET;
        end else begin
            if (full_bit && good_count_r != COUNT_SAT)
                good_count_r <= good_count_r + 8'h01;
            if (reject && bad_count_r != COUNT_SAT)
                bad_count_r <= bad_count_r + 8'h01;
            if (tx_done && packets_sent_counter_r != COUNT_SAT)
                packets_sent_counter_r <= packets_sent_counter_r + 8'h01;
        end
    end

    // Receive fsm; detection enable kept across protocol reset
    always_ff @(posedge clk_i) begin
        if (mac_clr) begin
            rx_state_r <= RX_IDLE;
            sticky_detect_r <= 1'b0;
        end else if (proto_clr) begin // RQ6
            rx_state_r <= RX_IDLE;
            sticky_detect_r <= sticky_detect_r
                | mac_ctl_r[BIT_RESET_DETECT_EN];
        end else begin
            if (mac_ctl_r[BIT_RX_ENABLE] && mac_ctl_r[BIT_RESET_DETECT_EN])
                sticky_detect_r <= 1'b1;
            unique case (rx_state_r)
                RX_IDLE: if (mac_ctl_r[BIT_RX_ENABLE]) rx_state_r <= RX_ARMED;
                RX_ARMED: if (full_bit) rx_state_r <= RX_FRAME;
                RX_FRAME: if (reject) rx_state_r <= RX_ARMED;
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (mac_clr) begin
            full_bit_o <= 1'b0;
            reset_evt_o <= 1'b0;
            tx_busy_o <= 1'b0;
        end else begin
            full_bit_o <= full_bit;
            reset_evt_o <= reset_seen_i & sticky_detect_r;
            tx_busy_o <= tx_busy;
        end
    end

    // Decoder measurement; codec reset restarts it but keeps limits
    high_bit_meter u_meter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rst_bus(rst_bus.user),
        .line_i(line_s2_r),
        .max_i(fb_max_r),
        .min_i(fb_min_r),
        .full_bit_o(full_bit),
        .reject_o(reject)
    );

    protocol_tx_fsm u_tx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rst_bus(rst_bus.user),
        .launch_i(mac_ctl_r[BIT_TX_LAUNCH]),
        .busy_o(tx_busy),
        .done_o(tx_done)
    );

    // Bus handshake: one answer, then one quiet cycle before the next
    sequence bus_take_s;
        req;
    endsequence

    sequence bus_answer_s;
        (ack_o ^ err_o) ##1 !(ack_o || err_o);
    endsequence

    // A protocol reset pulse that the full reset does not override
    sequence proto_only_s;
        proto_clr && !mac_clr;
    endsequence

    AST_RST_CLEARS_CTL: assert property ( // RQ3
        @(posedge clk_i) rst_i |=> mac_soft_reset_control_r == REG8_RESET)
        else $error("soft reset bits survived external reset");
    AST_FULL_CLEARS_LIMITS: assert property ( // RQ18
        @(posedge clk_i) disable iff (rst_i)
        mac_soft_reset_control_r[BIT_MAC_FULL_RESET] |=> fb_max_r == LIMIT_RESET
            && fb_min_r == LIMIT_RESET)
        else $error("limits kept through full reset");
    AST_FULL_CLEARS_STATE: assert property ( // RQ18
        @(posedge clk_i) disable iff (rst_i)
        mac_soft_reset_control_r[BIT_MAC_FULL_RESET] |=> mac_ctl_r == REG8_RESET
            && good_count_r == REG8_RESET && bad_count_r == REG8_RESET
            && rx_state_r == RX_IDLE && !sticky_detect_r)
        else $error("mac state kept through full reset");
    AST_FULL_QUIETS_OUTS: assert property ( // RQ18
        @(posedge clk_i) disable iff (rst_i)
        mac_soft_reset_control_r[BIT_MAC_FULL_RESET]
        |=> !full_bit_o && !reset_evt_o && !tx_busy_o)
        else $error("outputs active through full reset");
    AST_CODEC_KEEPS_LIMITS: assert property ( // RQ4
        @(posedge clk_i) disable iff (rst_i)
        mac_soft_reset_control_r[BIT_LINE_CODEC_RESET] && !mac_soft_reset_control_r[BIT_MAC_FULL_RESET]
        && !wr |=> $stable(fb_max_r) && $stable(fb_min_r))
        else $error("codec reset changed limits");
    AST_PROTO_TX_BITS: assert property ( // RQ8
        @(posedge clk_i) disable iff (rst_i)
        proto_clr |=> mac_ctl_r[3:0] == 4'h0)
        else $error("transmit bits survived protocol reset");
    AST_PROTO_RX_IDLE: assert property ( // RQ6
        @(posedge clk_i) disable iff (rst_i)
        proto_only_s |=> rx_state_r == RX_IDLE
            && sticky_detect_r == ($past(sticky_detect_r)
                | $past(mac_ctl_r[BIT_RESET_DETECT_EN])))
        else $error("receive fsm or detect enable wrong after protocol reset");
    AST_PROTO_KEEPS_COUNT: assert property ( // RQ9
        @(posedge clk_i) disable iff (rst_i)
        proto_clr && !mac_clr && !full_bit && !reject && !tx_done
        |=> $stable(good_count_r) && $stable(bad_count_r)
            && $stable(packets_sent_counter_r))
        else $error("protocol reset disturbed counters");
    AST_PROTO_KEEPS_LIMITS: assert property ( // RQ10
        @(posedge clk_i) disable iff (rst_i)
        proto_clr && !mac_clr && !wr
        |=> $stable(fb_max_r) && $stable(fb_min_r))
        else $error("protocol reset disturbed decoder limits");
    AST_DETECT_EVT: assert property ( // RQ6
        @(posedge clk_i) disable iff (rst_i)
        !mac_soft_reset_control_r[BIT_MAC_FULL_RESET] |=> reset_evt_o
            == ($past(reset_seen_i) && $past(sticky_detect_r)))
        else $error("reset event output wrong");
    AST_RX_ARMS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !mac_clr && !proto_clr && rx_state_r == RX_IDLE
            && mac_ctl_r[BIT_RX_ENABLE] |=> rx_state_r == RX_ARMED)
        else $error("receiver did not arm");
    AST_BUS_ANSWER: assert property (
        @(posedge clk_i) disable iff (rst_i)
        bus_take_s |=> bus_answer_s)
        else $error("bus request not answered exactly once");
    AST_ACK_ONE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    AST_DATA_QUIET: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data shown without ack");
    AST_CTL_WRITE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr && idx == IDX_SOFT_MAC_SOFT_RESET_CONTROL
        |=> mac_soft_reset_control_r == ($past(dat_i[7:0]) & MAC_SOFT_RESET_CONTROL_MASK))
        else $error("reset control write lost");
endmodule

// ===== hdl/pd_mac_pkg.sv
package pd_mac_pkg;
    // Register word addresses on Wishbone (byte address = index * 4)
    localparam logic [15:0] IDX_HIGH_FULL_BIT_MAX = 16'h1AA0;
    localparam logic [15:0] IDX_HIGH_FULL_BIT_MIN = 16'h1AA1;
    localparam logic [15:0] IDX_SOFT_MAC_SOFT_RESET_CONTROL = 16'h1A8B;
    localparam logic [15:0] IDX_DECODER_STATUS = 16'h1AB0;
    localparam logic [15:0] IDX_MAC_CONTROL = 16'h1AB1;
    localparam int ADDR_W = 18;
    // Soft reset control fields
    localparam int BIT_MAC_FULL_RESET = 7;
    localparam int BIT_LINE_CODEC_RESET = 6;
    localparam int BIT_PROTOCOL_RESET_DONE = 0;
    localparam logic [7:0] MAC_SOFT_RESET_CONTROL_MASK = 8'hC1;
    // MAC control fields
    localparam int BIT_TX_LAUNCH = 0;
    localparam int BIT_TX_HARD_RESET = 1;
    localparam int BIT_TX_CABLE_RESET = 2;
    localparam int BIT_FAST_TX_ENABLE = 3;
    localparam int BIT_RX_ENABLE = 4;
    localparam int BIT_RESET_DETECT_EN = 5;
    localparam logic [7:0] MAC_CONTROL_MASK = 8'h3F;
    // Reset values and counter saturation value
    localparam logic [7:0] LIMIT_RESET = 8'h00;
    localparam logic [7:0] REG8_RESET = 8'h00;
    localparam logic [7:0] COUNT_SAT = 8'hFF;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_ARMED = 2'b01,
        RX_FRAME = 2'b11
    } rx_state_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01,
        TX_DONE = 2'b11
    } tx_state_t;
endpackage

// ===== hdl/soft_reset_if.sv
`timescale 1ns/100ps
interface soft_reset_if;
    logic mac_reset;
    logic codec_reset;
    logic protocol_reset;
    modport ctrl(output mac_reset, output codec_reset, output protocol_reset);
    modport user(input mac_reset, input codec_reset, input protocol_reset);
endinterface

// ===== hdl/high_bit_meter.sv
`timescale 1ns/100ps
module high_bit_meter
    import pd_mac_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    soft_reset_if.user rst_bus,
    // Synchronised line and limits
    input wire logic line_i,
    input wire logic [7:0] max_i,
    input wire logic [7:0] min_i,
    // Results
    output logic full_bit_o,
    output logic reject_o
);
    logic line_d_r;
    logic [7:0] count_r;
    logic counting_r;
    logic codec_clr;
    logic rise;
    logic fall;

    assign codec_clr = rst_i | rst_bus.mac_reset | rst_bus.codec_reset; // RQ10
    assign rise = line_i & ~line_d_r;
    assign fall = ~line_i & line_d_r;

    // Count saturates so a stuck-high line is rejected, not wrapped
    always_ff @(posedge clk_i) begin
        if (codec_clr) begin // RQ4
            line_d_r <= 1'b0;
            count_r <= REG8_RESET;
            counting_r <= 1'b0;
        end else begin
            line_d_r <= line_i;
            if (rise) begin // RQ17
                count_r <= 8'h01;
                counting_r <= 1'b1;
            end else if (fall) begin
                counting_r <= 1'b0;
            end else if (counting_r && count_r != COUNT_SAT) begin
                count_r <= count_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (codec_clr) begin
            full_bit_o <= 1'b0;
            reject_o <= 1'b0;
        end else begin
            full_bit_o <= fall && counting_r && count_r > min_i
                && count_r < max_i; // RQ12
            reject_o <= fall && counting_r && !(count_r > min_i
                && count_r < max_i);
        end
    end

    AST_FULL_WINDOW: assert property ( // RQ12
        @(posedge clk_i) disable iff (codec_clr)
        full_bit_o |-> ($past(count_r) > $past(min_i)
            && $past(count_r) < $past(max_i)))
        else $error("full bit accepted outside window");
    AST_ONE_VERDICT: assert property ( // RQ17
        @(posedge clk_i) disable iff (codec_clr)
        fall && counting_r |=> full_bit_o ^ reject_o)
        else $error("falling edge without single verdict");
endmodule

// ===== hdl/protocol_tx_fsm.sv
`timescale 1ns/100ps
module protocol_tx_fsm
    import pd_mac_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    soft_reset_if.user rst_bus,
    // Launch request
    input wire logic launch_i,
    // State
    output logic busy_o,
    output logic done_o
);
    tx_state_t state_r;
    logic [3:0] shift_r;
    logic [3:0] nibble_r;

    // Serialiser and encoder stand-ins share the protocol reset
    always_ff @(posedge clk_i) begin
        if (rst_i || rst_bus.mac_reset || rst_bus.protocol_reset) begin // RQ7
            state_r <= TX_IDLE;
            shift_r <= 4'h0;
            nibble_r <= 4'h0;
        end else begin
            unique case (state_r)
                TX_IDLE: if (launch_i) begin
                    state_r <= TX_SEND;
                    shift_r <= 4'hF;
                    nibble_r <= 4'h0;
                end
                TX_SEND: begin
                    shift_r <= {1'b0, shift_r[3:1]};
                    nibble_r <= nibble_r + 4'h1;
                    // Sixteen slots: long enough for a protocol reset to cut
                    if (nibble_r == 4'hF) state_r <= TX_DONE;
                end
                TX_DONE: state_r <= TX_IDLE;
                default: state_r <= TX_IDLE;
            endcase
        end
    end

    assign busy_o = state_r == TX_SEND;
    assign done_o = state_r == TX_DONE;

    AST_TX_PROTO_IDLE: assert property ( // RQ7
        @(posedge clk_i) disable iff (rst_i)
        rst_bus.protocol_reset |=> state_r == TX_IDLE)
        else $error("tx fsm survived protocol reset");
endmodule

// ===== dv/line_partner.sv
`timescale 1ns/100ps
// Remote port partner: drives the received line, idle low between symbols
module line_partner (
    // Clock
    input wire logic clk_i,
    // Line towards the block
    output logic line_o
);
    initial line_o = 1'b0;

    // High level lasts exactly n clocks; the gap lets the result drain out
    task automatic send_high(input int n);
        @(posedge clk_i);
        line_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        line_o <= 1'b0;
        repeat (12) @(posedge clk_i);
    endtask
endmodule

// ===== dv/tb.sv
`timescale 1ns/100ps
module tb;
    import pd_mac_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [ADDR_W-1:0] adr_i = '0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic reset_seen_i = 1'b0;
    logic line_i;
    logic [31:0] dat_o;
    logic ack_o, err_o, full_bit_o, reset_evt_o, tx_busy_o;
    int errors = 0;
    int tests_run = 0;
    int seed = 10;
    int fb_seen = 0;
    int fb_exp = 0;
    int n;
    int lens[5] = '{116, 117, 201, 202, 3};
    // Each note holds {mask, expected byte}
    logic [15:0] exp_q[$];
    logic [15:0] e;

    always #50 clk_i = ~clk_i;

    line_partner u_line (.clk_i(clk_i), .line_o(line_i));

    pd_mac_reset_timing u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .line_i(line_i),
        .reset_seen_i(reset_seen_i), .full_bit_o(full_bit_o),
        .reset_evt_o(reset_evt_o), .tx_busy_o(tx_busy_o)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // For a read, d is the expected byte; upper data bits are noise
    task automatic wb(input logic w, input logic [15:0] idx,
                      input logic [7:0] d, input logic [7:0] mask,
                      input logic bad, input logic [3:0] s = 4'h1);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= s;
        dat_i <= ($random(seed) & 32'hFFFFFF00) | {24'h0, d};
        if (!w && !bad) begin
            exp_q.push_back({mask, d});
        end
        // Waits however long the answer takes; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1 && err_o !== 1'b1);
        check({ack_o, err_o}, {~bad, bad});
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic proto_reset;
        wb(1, IDX_SOFT_MAC_SOFT_RESET_CONTROL, 8'h01, 8'hFF, 0);
        wb(1, IDX_SOFT_MAC_SOFT_RESET_CONTROL, 8'h00, 8'hFF, 0);
    endtask

    task automatic set_limits;
        wb(1, IDX_HIGH_FULL_BIT_MAX, 8'hCA, 8'hFF, 0);
        wb(1, IDX_HIGH_FULL_BIT_MIN, 8'h74, 8'hFF, 0);
    endtask

    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            e = exp_q.pop_front();
            check(dat_o & {24'h0, e[15:8]}, {24'h0, e[7:0] & e[15:8]});
        end
        if (full_bit_o === 1'b1) begin
            fb_seen++;
        end
    end

    // Whole run is a few thousand clocks; this is far beyond it
    initial begin
        #2000000;
        errors++;
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, IDX_HIGH_FULL_BIT_MAX, LIMIT_RESET, 8'hFF, 0);
        wb(0, IDX_HIGH_FULL_BIT_MIN, LIMIT_RESET, 8'hFF, 0);
        wb(0, IDX_SOFT_MAC_SOFT_RESET_CONTROL, 8'h00, 8'hFF, 0);
        wb(0, IDX_MAC_CONTROL, 8'h00, 8'hFF, 0);
        wb(0, 16'h1AA2, 8'h00, 8'hFF, 1);
        set_limits();
        // Lane 0 not selected, so the write must leave min alone
        wb(1, IDX_HIGH_FULL_BIT_MIN, 8'h00, 8'hFF, 0, 4'hE);
        wb(0, IDX_HIGH_FULL_BIT_MIN, 8'h74, 8'hFF, 0);
        wb(0, IDX_HIGH_FULL_BIT_MAX, 8'hCA, 8'hFF, 0);
        $display("test registers done");
        for (int i = 0; i < 12; i++) begin
            n = (i < 5) ? lens[i] : 100 + ($unsigned($random(seed)) % 121);
            if (n > 116 && n < 202) begin
                fb_exp++;
            end
            u_line.send_high(n);
        end
        check(fb_seen, fb_exp);
        wb(0, IDX_DECODER_STATUS, 8'(fb_exp), 8'hFF, 0);
        $display("test full bit window done");
        wb(1, IDX_MAC_CONTROL, 8'h3F, 8'hFF, 0);
        repeat (2) @(posedge clk_i);
        check(tx_busy_o, 1'b1);
        proto_reset();
        check(tx_busy_o, 1'b0);
        // Receive and detect enables survive; bit 7 shows the sticky detect
        wb(0, IDX_MAC_CONTROL, 8'hB0, 8'hFF, 0);
        wb(0, IDX_DECODER_STATUS, 8'(fb_exp), 8'hFF, 0);
        wb(0, IDX_HIGH_FULL_BIT_MAX, 8'hCA, 8'hFF, 0);
        reset_seen_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check(reset_evt_o, 1'b1);
        proto_reset();
        repeat (4) @(posedge clk_i);
        check(reset_evt_o, 1'b1);
        $display("test protocol reset done");
        wb(1, IDX_SOFT_MAC_SOFT_RESET_CONTROL, 8'h40, 8'hFF, 0);
        wb(0, IDX_SOFT_MAC_SOFT_RESET_CONTROL, 8'h40, 8'hFF, 0);
        wb(1, IDX_SOFT_MAC_SOFT_RESET_CONTROL, 8'h00, 8'hFF, 0);
        wb(0, IDX_HIGH_FULL_BIT_MAX, 8'hCA, 8'hFF, 0);
        wb(0, IDX_HIGH_FULL_BIT_MIN, 8'h74, 8'hFF, 0);
        fb_exp++;
        u_line.send_high(150);
        check(fb_seen, fb_exp);
        $display("test codec reset done");
        wb(1, IDX_SOFT_MAC_SOFT_RESET_CONTROL, 8'h80, 8'hFF, 0);
        wb(0, IDX_HIGH_FULL_BIT_MAX, 8'h00, 8'hFF, 0);
        wb(0, IDX_SOFT_MAC_SOFT_RESET_CONTROL, 8'h80, 8'hFF, 0);
        check(reset_evt_o, 1'b0);
        wb(1, IDX_SOFT_MAC_SOFT_RESET_CONTROL, 8'h00, 8'hFF, 0);
        wb(0, IDX_MAC_CONTROL, 8'h00, 8'hFF, 0);
        wb(0, IDX_DECODER_STATUS, 8'h00, 8'hFF, 0);
        set_limits();
        wb(0, IDX_HIGH_FULL_BIT_MIN, 8'h74, 8'hFF, 0);
        $display("test full reset done");
        wb(1, IDX_SOFT_MAC_SOFT_RESET_CONTROL, 8'h80, 8'hFF, 0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, IDX_SOFT_MAC_SOFT_RESET_CONTROL, 8'h00, 8'hFF, 0);
        wb(0, IDX_HIGH_FULL_BIT_MAX, LIMIT_RESET, 8'hFF, 0);
        $display("test external reset done");
        end_of_test();
    end
endmodule
